// ---- dfi_pkg.sv ----
// constants for the decrement-file execution block
package dfi_pkg;
   localparam logic [5:0]  OPC_DECR      = 6'h01; // 0000 01da
   localparam int          OPC_LSB       = 10;
   localparam int          DEST_BIT      = 9;
   localparam int          BANK_BIT      = 8;
   localparam logic [3:0]  ACCESS_BANK   = 4'h0;
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
   localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
   localparam logic [7:0]  WORK_REG_RST  = 8'h00;
   localparam logic [3:0]  BANK_SEL_RST  = 4'h0;
   localparam logic [4:0]  FLAGS_RST     = 5'h00;
   localparam int          FLG_C         = 0;
   localparam int          FLG_NIB       = 1;
   localparam int          FLG_Z         = 2;
   localparam int          FLG_RANGE     = 3;
   localparam int          FLG_N         = 4;
   localparam int          MEM_DEPTH     = 4096;
   localparam int          ADDR_W        = 12;
endpackage : dfi_pkg

// ---- dfi_mem.sv ----
// data memory with registered read port
`timescale 1ns/100ps
`default_nettype none
module dfi_mem
   import dfi_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic [ADDR_W-1:0] i_raddr,
   input  wire logic              i_we,
   input  wire logic [ADDR_W-1:0] i_waddr,
   input  wire logic [7:0]        i_wdata,
   output logic      [7:0]        o_rdata
);
   logic [7:0] mem [MEM_DEPTH];

   // no reset on the array; contents are undefined until written
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule : dfi_mem
`default_nettype wire

// ---- dfi_core.sv ----
// decrement-file instruction execution: read, decrement, write back
`timescale 1ns/100ps
`default_nettype none
module dfi_core
   import dfi_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_valid,
   input  wire logic [15:0]       i_instr,
   input  wire logic              i_bank_sel_we,
   input  wire logic [3:0]        i_bank_sel_data,
   input  wire logic              i_mem_we,
   input  wire logic [ADDR_W-1:0] i_mem_addr,
   input  wire logic [7:0]        i_mem_data,
   output logic      [7:0]        o_work_reg,
   output logic      [4:0]        o_status,
   output logic                   o_done,
   output logic      [ADDR_W-1:0] o_wr_addr,
   output logic      [7:0]        o_wr_data,
   output logic                   o_wr_mem
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} dfi_state_t;

   dfi_state_t        state_ff;
   logic [3:0]        bank_sel_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic              dest_ff;
   logic [7:0]        rdata;
   logic [7:0]        result;
   logic [4:0]        nxt_flags;
   logic [4:0]        nxt_nib_tmp;
   logic              is_decr;
   logic [ADDR_W-1:0] eff_addr;
   logic              exec_we;
   logic              mem_we;
   logic [ADDR_W-1:0] mem_waddr;
   logic [7:0]        mem_wdata;

   assign is_decr = i_valid && (i_instr[15:OPC_LSB] == OPC_DECR);

   // access bank low half maps to bank 0, high half to bank f
   always_comb begin
      if (!i_instr[BANK_BIT]) begin
         if (i_instr[7:0] < ACCESS_SPLIT) begin
            eff_addr = {ACCESS_BANK, i_instr[7:0]};
         end else begin
            eff_addr = {ACCESS_HI_BNK, i_instr[7:0]};
         end
      end else begin
         eff_addr = {bank_sel_ff, i_instr[7:0]};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bank_sel_ff <= BANK_SEL_RST;
      end else if (i_bank_sel_we) begin
         bank_sel_ff <= i_bank_sel_data;
      end
   end

   // new instructions are ignored while one is in flight
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= ST_IDLE;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (is_decr) begin
                  state_ff <= ST_READ;
               end
            end
            ST_READ: begin
               state_ff <= ST_EXEC;
            end
            ST_EXEC: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_ff <= '0;
         dest_ff <= 1'b0;
      end else if (state_ff == ST_IDLE && is_decr) begin
         addr_ff <= eff_addr;
         dest_ff <= i_instr[DEST_BIT];
      end
   end

   // read data arrives one cycle after the address is registered
   assign result = rdata - 8'h01;
   assign nxt_nib_tmp = {1'b0, rdata[3:0]} - 5'h01;

   always_comb begin
      nxt_flags            = FLAGS_RST;
      // borrow-style carry: set when no borrow occurs
      nxt_flags[FLG_C]     = (rdata != 8'h00);
      nxt_flags[FLG_NIB]   = !nxt_nib_tmp[4];
      nxt_flags[FLG_Z]     = (result == 8'h00);
      nxt_flags[FLG_N]     = result[7];
      nxt_flags[FLG_RANGE] = (rdata == 8'h80);
   end

   assign exec_we = (state_ff == ST_EXEC);

   // external loads share the write port only when no write-back is due
   always_comb begin
      if (exec_we && dest_ff) begin
         mem_we    = 1'b1;
         mem_waddr = addr_ff;
         mem_wdata = result;
      end else begin
         mem_we    = i_mem_we;
         mem_waddr = i_mem_addr;
         mem_wdata = i_mem_data;
      end
   end

   dfi_mem u_mem (
      .i_clk   (i_clk),
      .i_raddr (addr_ff),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .o_rdata (rdata)
   );

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_work_reg <= WORK_REG_RST;
      end else if (exec_we && !dest_ff) begin
         o_work_reg <= result;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_status <= FLAGS_RST;
      end else if (exec_we) begin
         o_status <= nxt_flags;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_done    <= 1'b0;
         o_wr_mem  <= 1'b0;
         o_wr_addr <= '0;
         o_wr_data <= 8'h00;
      end else begin
         o_done    <= exec_we;
         o_wr_mem  <= exec_we && dest_ff;
         // held between executions; the read port keeps re-reading
         if (exec_we) begin
            o_wr_addr <= addr_ff;
            o_wr_data <= result;
         end
      end
   end

   AST_WORK_REG_RESULT: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (exec_we && !dest_ff) |=> (o_work_reg == $past(rdata) - 8'h01))
      else $error("working register not loaded with decremented value");

   AST_WORK_REG_HOLD: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (exec_we && dest_ff) |=> $stable(o_work_reg))
      else $error("working register changed on memory destination");

   AST_MEM_WB: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (exec_we && dest_ff) |=> (o_wr_mem && o_wr_data == $past(result)))
      else $error("write-back to memory missing");

   AST_NO_MEM_WB: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (exec_we && !dest_ff) |=> !o_wr_mem)
      else $error("memory written when destination is working register");

   AST_DEC_WRAP: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (exec_we && rdata == 8'h00) |=> (o_wr_data == 8'hff))
      else $error("decrement of zero did not wrap");

   AST_ZERO_FLAG: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      exec_we |=> (o_status[FLG_Z] == (o_wr_data == 8'h00)))
      else $error("zero flag disagrees with result");

   AST_ACCESS_BANK: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (state_ff == ST_IDLE && is_decr && !i_instr[BANK_BIT]
       && i_instr[7] == 1'b0) |=> (addr_ff[11:8] == ACCESS_BANK))
      else $error("access bank not selected");

   AST_BANK_SEL: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (state_ff == ST_IDLE && is_decr && i_instr[BANK_BIT])
      |=> (addr_ff[11:8] == $past(bank_sel_ff)))
      else $error("bank select register not used");

   AST_DONE_TIME: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (state_ff == ST_IDLE && is_decr) |-> ##3 o_done)
      else $error("instruction did not complete in three cycles");
endmodule : dfi_core
`default_nettype wire

// ---- decrement_register_instruction_test.sv ----
// self-checking bench for the decrement-file execution block
`timescale 1ns/100ps
`default_nettype none
module decrement_register_instruction_test import dfi_pkg::*;;
   logic              i_clk;
   logic              i_rst_n;
   logic              i_valid;
   logic [15:0]       i_instr;
   logic              i_bank_sel_we;
   logic [3:0]        i_bank_sel_data;
   logic              i_mem_we;
   logic [ADDR_W-1:0] i_mem_addr;
   logic [7:0]        i_mem_data;
   logic [7:0]        o_work_reg;
   logic [7:0]        exp_work_reg;
   logic [4:0]        o_status;
   logic              o_done;
   logic [ADDR_W-1:0] o_wr_addr;
   logic [7:0]        o_wr_data;
   logic              o_wr_mem;
   int                fails;
   int                total_checks;
   logic [7:0]        vals [6] = '{8'h00, 8'h01, 8'h80, 8'h10, 8'hff, 8'ha5};

   dfi_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
      .i_instr(i_instr), .i_bank_sel_we(i_bank_sel_we),
      .i_bank_sel_data(i_bank_sel_data),
      .i_mem_we(i_mem_we), .i_mem_addr(i_mem_addr),
      .i_mem_data(i_mem_data), .o_work_reg(o_work_reg),
      .o_status(o_status),
      .o_done(o_done), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
      .o_wr_mem(o_wr_mem));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [11:0] e, g);
      total_checks++;
      if (e !== g) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // backdoor loads only while idle, so no write-back collision
   task automatic load(input logic [11:0] ad, input logic [7:0] dt);
      i_mem_we = 1'b1;
      i_mem_addr = ad;
      i_mem_data = dt;
      @(negedge i_clk);
      i_mem_we = 1'b0;
   endtask : load

   task automatic run_op(input logic d, a, input logic [7:0] f, v,
                         input logic [11:0] ad);
      logic [7:0] res;
      logic [4:0] flg;
      int n;
      res = v - 8'h01;
      flg = FLAGS_RST;
      flg[FLG_C] = (v != 8'h00);
      flg[FLG_NIB] = (v[3:0] != 4'h0);
      flg[FLG_Z] = (res == 8'h00);
      flg[FLG_RANGE] = (v == 8'h80);
      flg[FLG_N] = res[7];
      // memory destination must leave the working register alone
      if (!d) begin
         exp_work_reg = res;
      end
      i_valid = 1'b1;
      i_instr = {OPC_DECR, d, a, f};
      @(negedge i_clk);
      i_valid = 1'b0;
      n = 0;
      while (o_done !== 1'b1 && n < 8) begin
         @(negedge i_clk);
         n++;
      end
      if (n == 8) begin
         fails++;
         $display("BAD done expected 1 seen %b", o_done);
         close_out();
      end
      chk("result", {4'h0, res}, {4'h0, o_wr_data});
      chk("work_reg", {4'h0, exp_work_reg}, {4'h0, o_work_reg});
      chk("wr_mem", {11'h0, d}, {11'h0, o_wr_mem});
      chk("status", {7'h0, flg}, {7'h0, o_status});
      chk("addr", ad, o_wr_addr);
      // done is a single-cycle pulse, the result word must stand
      @(negedge i_clk);
      chk("done_pulse", 12'h000, {11'h0, o_done});
      chk("wr_data_hold", {4'h0, res}, {4'h0, o_wr_data});
   endtask : run_op

   task automatic t_flags();
      foreach (vals[i]) begin
         load(12'h005, vals[i]);
         run_op(1'b0, 1'b0, 8'h05, vals[i], 12'h005);
      end
      $display("flags test done");
   endtask : t_flags

   task automatic t_dest();
      load(12'h033, 8'h42);
      run_op(1'b1, 1'b0, 8'h33, 8'h42, 12'h033);
      run_op(1'b0, 1'b0, 8'h33, 8'h41, 12'h033);
      // memory must still hold the earlier value
      run_op(1'b0, 1'b0, 8'h33, 8'h41, 12'h033);
      $display("destination test done");
   endtask : t_dest

   task automatic t_bank();
      i_bank_sel_we = 1'b1;
      i_bank_sel_data = 4'h5;
      @(negedge i_clk);
      i_bank_sel_we = 1'b0;
      load(12'h520, 8'h11);
      load(12'h020, 8'h22);
      load(12'hf90, 8'h33);
      run_op(1'b1, 1'b1, 8'h20, 8'h11, 12'h520);
      run_op(1'b1, 1'b0, 8'h20, 8'h22, 12'h020);
      run_op(1'b1, 1'b0, 8'h90, 8'h33, 12'hf90);
      $display("bank test done");
   endtask : t_bank

   initial begin
      fails = 0;
      total_checks = 0;
      i_rst_n = 1'b0;
      i_valid = 1'b0;
      i_instr = 16'h0000;
      exp_work_reg = WORK_REG_RST;
      i_bank_sel_we = 1'b0;
      i_bank_sel_data = 4'h0;
      i_mem_we = 1'b0;
      i_mem_addr = 12'h000;
      i_mem_data = 8'h00;
      repeat (3) @(negedge i_clk);
      i_rst_n = 1'b1;
      @(negedge i_clk);
      t_flags();
      t_dest();
      t_bank();
      close_out();
   end
endmodule : decrement_register_instruction_test
`default_nettype wire
